/* shared/rst_params.svh */
// timing, field and offset constants for the reset source tracker
`ifndef RST_PARAMS_SVH
`define RST_PARAMS_SVH
`define RST_ADDR_CAUSE      4'h0
`define RST_ADDR_STAT       4'h1
`define RST_ADDR_IEN        4'h2
`define RST_ADDR_ICLR       4'h3
`define RST_ADDR_MONCTL     4'h4
`define RST_ADDR_PEND       4'h5
`define RST_BIT_PIN         0
`define RST_BIT_POR         1
`define RST_BIT_MCD         2
`define RST_BIT_WDT         3
`define RST_BIT_SW          4
`define RST_BIT_CMP         5
`define RST_BIT_FLT         6
`define RST_BIT_TOP         7
`define RST_FETCH_ADDR      16'h0000
`define RST_POR_DELAY_US    100
`define RST_CLK_MHZ         125
`define RST_POR_CYCLES      (`RST_POR_DELAY_US * `RST_CLK_MHZ)
`define RST_HOLD_CYCLES     8'h08
`endif

/* shared/rst_pkg.sv */
// types shared by the reset source tracker
package rst_pkg;
    typedef struct packed {
        logic addrValid;
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rst_bus_s;
    typedef struct packed {
        logic pinRst;
        logic supplyLow;
        logic clockMissing;
        logic watchdog;
        logic comparatorLow;
        logic flashFault;
    } rst_src_s;
    typedef enum logic [2:0] {
        ST_POWERUP = 3'b001,
        ST_DELAY   = 3'b010,
        ST_RUN     = 3'b100
    } rst_state_e;
endpackage

/* core/rst_sync2.sv */
// two-flop synchroniser for asynchronous level inputs
module rst_sync2 #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] stage1;   // metastable stage, only read by stage 2
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stage1 <= '0;
            dout   <= '0;
        end
        else
        begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule // rst_sync2

/* core/rst_source_tracker.sv */
// reset sequencer and reset cause register
//
// Notes on behaviour
// [R1] hold reset, pin low, then delay
// [R2] power-on flag set on POR only; the code also sets it on an armed supply-low reset
// [R3] all resets restart at fetch zero
// [R4] POR enables both supply monitors
// [R5] flash fault flag reads last cause
// [R6] comparator enable write, cause read
// [R7] software force resets, flag reads cause
// [R8] watchdog flag reads last cause
// [R9] missing clock enable write, cause read
// [R10] power flag write arms supply monitor
// [R11] pin flag reads last cause
// [R12] software writes whole register directly
// [R13] software writes power bit as one
// [R14] startup enables monitor then source
// [R15] flash code arms monitor before operation
// [R16] interrupts pend during flash operation
// [R17] non-POR reset keeps only its cause
// [R18] top bit reads one, ignores writes
`include "rst_params.svh"
module rst_source_tracker (
    input  wire logic             core_clk,      // system clock
    input  wire logic             arst_n,        // power-on reset
    input  wire logic             supplyOk,      // supply above threshold
    input  wire rst_pkg::rst_src_s srcIn,        // raw reset requests
    input  wire logic             flashBusy,     // flash write/erase active
    input  wire logic [7:0]       irqPost,       // interrupts posted
    input  wire logic             irqGlobalEn,   // core interrupts enabled
    input  wire rst_pkg::rst_bus_s bus,          // register port
    output logic      [7:0]       rdata,         // read data
    output logic                  sysRst,        // system reset to core
    output logic                  rstPinOut,     // reset pin drive value
    output logic                  rstPinOe,      // reset pin drive enable
    output logic      [15:0]      fetchAddr,     // restart fetch address
    output logic                  primaryMonEn,  // primary supply monitor on
    output logic                  secondaryMonEn,// secondary supply monitor on
    output logic      [7:0]       irqRelease,    // pending interrupts to core
    output logic                  irq            // event interrupt
);
    import rst_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // synchronised inputs
    rst_src_s srcSync;                  // synced reset requests
    logic     supplyOkSync;             // synced supply good
    rst_sync2 #(.W(7)) uSync (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .din      ({srcIn, supplyOk}),
        .dout     ({srcSync, supplyOkSync})
    );

    ////////////////////////////////////////////////////////////////////////
    // state and registers
    rst_state_e state;                  // sequencer state
    logic [13:0] porCnt;                // power-on delay counter
    logic [7:0]  holdCnt;               // reset hold for other causes
    logic [6:0]  cause;                 // recorded cause flags
    logic        cmpEn;                 // comparator as reset source
    logic        mcdEn;                 // missing clock as reset source
    logic        supEn;                 // supply monitor as reset source
    logic [6:0]  stat;                  // sticky event status
    logic [6:0]  ien;                   // event interrupt enable
    logic [7:0]  pend;                  // held interrupts

    // decode
    wire running   = (state == ST_RUN);
    wire wrCause   = bus.wr && bus.addr == `RST_ADDR_CAUSE;
    wire wrIen     = bus.wr && bus.addr == `RST_ADDR_IEN;
    wire wrIclr    = bus.wr && bus.addr == `RST_ADDR_ICLR;
    wire wrMon     = bus.wr && bus.addr == `RST_ADDR_MONCTL;
    // [R7] software force
    wire swForce   = wrCause && bus.wdata[`RST_BIT_SW];
    // [R5] [R8] [R11] read-only cause sources
    // hardware sources (supply, clock and comparator gated), in priority order except supply, which ranks above pin
    wire hitPin    = srcSync.pinRst;
    wire hitSup    = supEn && primaryMonEn && srcSync.supplyLow;
    wire hitMcd    = mcdEn && srcSync.clockMissing;
    wire hitWdt    = srcSync.watchdog;
    wire hitCmp    = cmpEn && srcSync.comparatorLow;
    wire hitFlt    = srcSync.flashFault;
    wire anyHit    = running && (hitPin | hitSup | hitMcd | hitWdt | hitCmp | hitFlt | swForce);
    // reset stays on while not running, on a hit, or during the hold
    wire holdReset = !running || anyHit || (holdCnt > 8'h01);
    // [R17] one-hot cause
    wire [6:0] newCause =
        hitSup ? 7'h02 :
        hitPin ? 7'h01 :
        hitMcd ? 7'h04 :
        hitWdt ? 7'h08 :
        swForce ? 7'h10 :
        hitCmp ? 7'h20 : 7'h40;
    wire [6:0] next_stat = (stat & ~(wrIclr ? bus.wdata[6:0] : 7'h00)) | (anyHit ? newCause : 7'h00);
    // [R18] top bit fixed at one
    wire [7:0] causeView = {1'b1, cause[6], cause[5] , cause[4], cause[3], cause[2], cause[1], cause[0]};
    wire [7:0] rdMux =
        (bus.addr == `RST_ADDR_CAUSE)  ? causeView :
        (bus.addr == `RST_ADDR_STAT)   ? {1'b0, stat} :
        (bus.addr == `RST_ADDR_IEN)    ? {1'b0, ien} :
        (bus.addr == `RST_ADDR_MONCTL) ? {6'h00, secondaryMonEn, primaryMonEn} :
        (bus.addr == `RST_ADDR_PEND)   ? pend : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // [R1] power-up sequencer
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state   <= ST_POWERUP;
            porCnt  <= '0;
            holdCnt <= '0;
        end
        else
        begin
            case (state)
                ST_POWERUP:
                begin
                    porCnt <= '0;
                    if (supplyOkSync)
                        state <= ST_DELAY;
                end
                ST_DELAY:
                begin
                    // power-on delay then release
                    if (!supplyOkSync)
                        state <= ST_POWERUP;
                    else if (porCnt == 14'(`RST_POR_CYCLES - 1))
                        state <= ST_RUN;
                    else
                        porCnt <= porCnt + 14'h0001;
                end
                ST_RUN:
                begin
                    // brown-out with monitor armed goes back to power-up hold
                    if (anyHit && hitSup)
                        state <= ST_POWERUP;
                    else if (anyHit)
                        holdCnt <= `RST_HOLD_CYCLES;
                    else if (holdCnt != 8'h00)
                        holdCnt <= holdCnt - 8'h01;
                end
                default:
                    state <= ST_POWERUP;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cause flags and source enables
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            // [R2] power-on cause
            cause <= 7'h02;
            cmpEn <= 1'b0;
            mcdEn <= 1'b0;
            supEn <= 1'b1;
        end
        else if (anyHit)
        begin
            // [R17] only causing flag
            cause <= newCause;
            cmpEn <= 1'b0;
            mcdEn <= 1'b0;
            supEn <= 1'b1;
        end
        else if (wrCause)
        begin
            // [R6] [R9] [R10] writable enables
            cmpEn <= bus.wdata[`RST_BIT_CMP];
            mcdEn <= bus.wdata[`RST_BIT_MCD];
            supEn <= bus.wdata[`RST_BIT_POR];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // supply monitor enables
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            // [R4] monitors on after power-on
            primaryMonEn   <= 1'b1;
            secondaryMonEn <= 1'b1;
        end
        else if (wrMon)
        begin
            // software may switch either monitor
            primaryMonEn   <= bus.wdata[0];
            secondaryMonEn <= bus.wdata[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event status and interrupt request
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            // nothing pending, nothing enabled
            stat <= '0;
            ien  <= '0;
            irq  <= 1'b0;
        end
        else
        begin
            // set wins over clear
            stat <= next_stat;
            if (wrIen)
                ien <= bus.wdata[6:0];
            // level follows the new status and mask
            irq  <= |(next_stat & (wrIen ? bus.wdata[6:0] : ien));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // [R16] interrupts held while flash is busy
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pend       <= '0;
            irqRelease <= '0;
        end
        else if (flashBusy || !irqGlobalEn)
        begin
            // collect, release nothing
            pend       <= pend | irqPost;
            irqRelease <= 8'h00;
        end
        else
        begin
            // hand held and new requests over at once
            irqRelease <= pend | irqPost;
            pend       <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port and reset outputs
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            // chip held in reset, pin pulled low
            rdata     <= '0;
            sysRst    <= 1'b1;
            rstPinOut <= 1'b0;
            rstPinOe  <= 1'b1;
            fetchAddr <= `RST_FETCH_ADDR;
        end
        else
        begin
            // read data stand for one cycle only
            rdata     <= bus.rd ? rdMux : 8'h00;
            sysRst    <= holdReset;
            // [R1] pin driven low while held
            rstPinOe  <= holdReset;
            rstPinOut <= 1'b0;
            // [R3] same fetch address
            fetchAddr <= `RST_FETCH_ADDR;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    // [R1] reset held through sequence
    AST_POR_HOLD: assert property (@(posedge core_clk) disable iff (!arst_n) // [R1]
        (state != ST_RUN) |=> sysRst && rstPinOe)
        else $error("reset released before sequence end");
    // [R1] pin driven while not running
    AST_PIN_DRIVE: assert property (@(posedge core_clk) disable iff (!arst_n) // [R1]
        !running |=> rstPinOe && !rstPinOut)
        else $error("reset pin not driven low");
    // [R1] supply loss restarts delay
    AST_POR_DROP: assert property (@(posedge core_clk) disable iff (!arst_n) // [R1]
        state == ST_DELAY && !supplyOkSync |=> state == ST_POWERUP)
        else $error("delay kept without supply");
    // [R2] power flag on supply reset
    AST_POR_SET: assert property (@(posedge core_clk) disable iff (!arst_n) // [R2]
        running && hitSup |=> cause == 7'h02)
        else $error("power flag not set on supply reset");
    // [R2] power flag cleared by others
    AST_POR_FLAG: assert property (@(posedge core_clk) disable iff (!arst_n) // [R2]
        anyHit && !hitSup |=> !cause[`RST_BIT_POR])
        else $error("power flag kept on other reset");
    // [R3] fixed restart address
    AST_FETCH: assert property (@(posedge core_clk) disable iff (!arst_n) // [R3]
        $fell(sysRst) |-> fetchAddr == `RST_FETCH_ADDR)
        else $error("wrong restart address");
    // [R5] flash fault cause
    AST_FLT: assert property (@(posedge core_clk) disable iff (!arst_n) // [R5]
        running && hitFlt && !hitSup && !hitPin && !hitMcd && !hitWdt && !swForce && !hitCmp |=> cause == 7'h40)
        else $error("flash fault cause missing");
    // [R6] comparator cause
    AST_CMP: assert property (@(posedge core_clk) disable iff (!arst_n) // [R6]
        running && hitCmp && !hitSup && !hitPin && !hitMcd && !hitWdt && !swForce |=> cause == 7'h20)
        else $error("comparator cause missing");
    // [R7] software force
    AST_SW_FORCE: assert property (@(posedge core_clk) disable iff (!arst_n) // [R7]
        running && swForce && !hitSup && !hitPin && !hitMcd && !hitWdt |=> sysRst && cause == 7'h10)
        else $error("software reset not forced");
    // [R7] software reset held
    AST_SW_HOLD: assert property (@(posedge core_clk) disable iff (!arst_n) // [R7]
        running && swForce |=> sysRst [*7])
        else $error("software reset too short");
    // [R8] watchdog cause
    AST_WDT: assert property (@(posedge core_clk) disable iff (!arst_n) // [R8]
        running && hitWdt && !hitSup && !hitPin && !hitMcd |=> cause[`RST_BIT_WDT])
        else $error("watchdog cause missing");
    // [R9] detector off, no reset
    AST_MCD_OFF: assert property (@(posedge core_clk) disable iff (!arst_n) // [R9]
        running && !mcdEn && srcSync.clockMissing && !anyHit |=> cause == $past(cause))
        else $error("disabled clock detector reset");
    // [R9] detector cause
    AST_MCD_ON: assert property (@(posedge core_clk) disable iff (!arst_n) // [R9]
        running && hitMcd && !hitSup && !hitPin |=> cause == 7'h04)
        else $error("clock detector cause missing");
    // [R10] armed supply loss restarts
    AST_SUP_HOLD: assert property (@(posedge core_clk) disable iff (!arst_n) // [R10]
        running && hitSup |=> state == ST_POWERUP)
        else $error("supply reset did not restart");
    // [R11] pin cause
    AST_PIN: assert property (@(posedge core_clk) disable iff (!arst_n) // [R11]
        running && hitPin && !hitSup |=> cause == 7'h01)
        else $error("pin cause missing");
    // [R16] nothing released while busy
    AST_PEND: assert property (@(posedge core_clk) disable iff (!arst_n) // [R16]
        flashBusy |=> irqRelease == 8'h00)
        else $error("interrupt released during flash");
    // [R16] posted requests kept
    AST_PEND_KEEP: assert property (@(posedge core_clk) disable iff (!arst_n) // [R16]
        (flashBusy || !irqGlobalEn) && irqPost != 8'h00 |=> (pend & $past(irqPost)) == $past(irqPost))
        else $error("posted interrupt lost");
    // [R17] single cause kept
    AST_ONEHOT: assert property (@(posedge core_clk) disable iff (!arst_n) // [R17]
        anyHit |=> $onehot(cause))
        else $error("cause not one-hot");
    // [R17] cause moves only on reset
    AST_CAUSE_HOLD: assert property (@(posedge core_clk) disable iff (!arst_n) // [R17]
        !anyHit |=> cause == $past(cause))
        else $error("cause changed without reset");
    // [R18] top bit reads one
    AST_TOP: assert property (@(posedge core_clk) disable iff (!arst_n) // [R18]
        bus.rd && bus.addr == `RST_ADDR_CAUSE |=> rdata[`RST_BIT_TOP])
        else $error("top bit not one");
    // main scenarios
    COV_SW: cover property (@(posedge core_clk) disable iff (!arst_n) running && swForce);
    COV_PIN: cover property (@(posedge core_clk) disable iff (!arst_n) running && hitPin);
    COV_RUN: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(running));
    COV_SUPPLY: cover property (@(posedge core_clk) disable iff (!arst_n) running && hitSup);
    COV_HELD: cover property (@(posedge core_clk) disable iff (!arst_n) flashBusy && irqPost != 8'h00);
endmodule // rst_source_tracker

/* verification/rst_partner_model.sv */
// model of the reset pin and the internal reset requesters
module rst_partner_model
    import rst_pkg::*;
(
    input  wire logic       core_clk, // system clock
    input  wire logic       go,       // start one request
    input  wire logic [2:0] sel,      // 0 pin 1 supply 2 clock 3 dog 4 cmp 5 flash
    input  wire logic       sysRst,   // device reset seen
    output rst_pkg::rst_src_s srcOut  // requests to the device
);
    logic [4:0] holdCnt = '0; // cycles a request has stood
    logic [5:0] active  = '0; // one-hot request, pin at the top
    assign srcOut = rst_src_s'(active);
    ////////////////////////////////////////////////////////////
    // hold a request until reset is seen or it times out
    // any one of the six requests, chosen by sel
    always @(posedge core_clk)
    begin
        if (go)
        begin
            active <= 6'h20 >> sel;
            holdCnt <= '0;
        end
        else if (sysRst || holdCnt == 5'h14)
            active <= '0;   // released lines fall back inactive
        else if (active != '0)
            holdCnt <= holdCnt + 5'h01;
    end
endmodule // rst_partner_model

/* verification/tb_top.sv */
// self-checking bench for the reset source tracker
`include "rst_params.svh"
module tb_top;
    import rst_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, arst_n = 0, supplyOk = 0, flashBusy = 0, irqGlobalEn = 0, go = 0, rdSeen = 0;
    logic [7:0] irqPost = '0, rdata, irqRelease, v;
    logic [2:0] sel = '0;
    rst_bus_s bus = '0;
    rst_src_s srcIn;
    logic sysRst, rstPinOut, rstPinOe, primaryMonEn, secondaryMonEn, irq;
    logic [15:0] fetchAddr;
    logic [31:0] lfsr = 32'hb6150a8b;
    logic [7:0] expQ[$];
    int error_cnt = 0, checks = 0;
    wire pinLevel = rstPinOe ? rstPinOut : 1'b1; // pulled up when released
    always #4 core_clk = ~core_clk;
    rst_source_tracker dut_u (.core_clk(core_clk), .arst_n(arst_n), .supplyOk(supplyOk), .srcIn(srcIn),
        .flashBusy(flashBusy), .irqPost(irqPost), .irqGlobalEn(irqGlobalEn), .bus(bus), .rdata(rdata),
        .sysRst(sysRst), .rstPinOut(rstPinOut), .rstPinOe(rstPinOe), .fetchAddr(fetchAddr),
        .primaryMonEn(primaryMonEn), .secondaryMonEn(secondaryMonEn), .irqRelease(irqRelease), .irq(irq));
    rst_partner_model part_u (.core_clk(core_clk), .go(go), .sel(sel), .sysRst(sysRst), .srcOut(srcIn));
    ////////////////////////////////////////////////////////////
    // compare, verdict and bus helpers
    function automatic logic [31:0] lfsrNext(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic acc(input logic [3:0] a, input logic [7:0] d, input logic w);
        bus <= '{addrValid: 1'b1, addr: a, wdata: d, wr: w, rd: !w};
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        expQ.push_back(e);
        acc(a, 8'h00, 1'b0);
    endtask
    task automatic settle(input int n);
        bus <= '0;
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic waitRst(input logic lvl, input int lim);
        for (int n = 0; n < lim && sysRst !== lvl; n++)
            @(posedge core_clk) #1;
        chk("sysRst", sysRst, lvl);
    endtask
    task automatic pulse(input logic [2:0] s);
        sel <= s;
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////
    // read data checker: oldest note against the answer cycle
    always @(posedge core_clk)
    begin
        if (rdSeen)
            chk("rdata", rdata, expQ.pop_front());
        rdSeen <= bus.rd;
    end
    // watchdog on the whole run
    initial
    begin
        repeat (40000) @(posedge core_clk);
        error_cnt++;
        close_out();
    end
    ////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        logic [2:0] srcSel[6] = '{3'd0, 3'd2, 3'd3, 3'd4, 3'd5, 3'd7};
        logic [7:0] enBits[6] = '{8'h00, 8'h04, 8'h00, 8'h20, 8'h00, 8'h10};
        logic [7:0] flag[6]   = '{8'h01, 8'h04, 8'h08, 8'h20, 8'h40, 8'h10};
        repeat (2) @(posedge core_clk) #1;
        chk("pin in reset", pinLevel, 0);
        chk("monitors", {primaryMonEn, secondaryMonEn}, 2'b11);
        arst_n <= 1'b1;
        repeat (40) @(posedge core_clk) #1;
        chk("held for supply", sysRst, 1);
        supplyOk <= 1'b1;
        repeat (12000) @(posedge core_clk) #1;
        chk("held for delay", sysRst, 1);
        waitRst(1'b0, 1000);
        chk("pin released", pinLevel, 1);
        chk("fetch", fetchAddr, `RST_FETCH_ADDR);
        rd(`RST_ADDR_CAUSE, 8'h82);
        rd(`RST_ADDR_MONCTL, 8'h03);
        rd(4'hf, 8'h00);
        acc(`RST_ADDR_MONCTL, 8'h03, 1'b1);
        acc(`RST_ADDR_CAUSE, 8'h02, 1'b1);
        acc(`RST_ADDR_ICLR, 8'hff, 1'b1);
        acc(`RST_ADDR_IEN, 8'h00, 1'b1);
        settle(2);
        // one reset from every cause but supply, enables written whole with power bit set
        for (int i = 0; i < 6; i++)
        begin
            acc(`RST_ADDR_CAUSE, 8'h02 | enBits[i], 1'b1);
            settle(2);
            if (srcSel[i] != 3'd7)
                pulse(srcSel[i]);
            waitRst(1'b1, 40);
            waitRst(1'b0, 100);
            chk("fetch", fetchAddr, `RST_FETCH_ADDR);
            rd(`RST_ADDR_CAUSE, 8'h80 | flag[i]);
            settle(2);
        end
        // detector left disabled: no reset
        pulse(3'd2);
        repeat (30) @(posedge core_clk) #1;
        chk("clock detector off", sysRst, 0);
        chk("irq masked", irq, 0);
        rd(`RST_ADDR_STAT, 8'h7d);
        acc(`RST_ADDR_IEN, 8'h08, 1'b1);
        settle(2);
        chk("irq raised", irq, 1);
        acc(`RST_ADDR_ICLR, 8'h08, 1'b1);
        settle(2);
        chk("irq cleared", irq, 0);
        rd(`RST_ADDR_STAT, 8'h75);
        settle(2);
        // interrupts held back while flash is busy
        lfsr = lfsrNext(lfsr);
        v = lfsr[7:0] | 8'h01;
        flashBusy <= 1'b1;
        irqPost <= v;
        settle(1);
        irqPost <= '0;
        settle(5);
        chk("irq held", irqRelease, 0);
        flashBusy <= 1'b0;
        irqGlobalEn <= 1'b1;
        for (int n = 0; n < 10 && irqRelease === 8'h00; n++)
            @(posedge core_clk) #1;
        chk("irq released", irqRelease, v);
        // arm the supply monitor, then raise a supply-low request
        acc(`RST_ADDR_CAUSE, 8'h02, 1'b1);
        settle(2);
        pulse(3'd1);
        waitRst(1'b1, 40);
        chk("pin on supply", pinLevel, 0);
        waitRst(1'b0, 13000);
        rd(`RST_ADDR_CAUSE, 8'h82);
        settle(3);
        close_out();
    end
endmodule // tb_top
